// [hw/fio_core.sv]
`timescale 1ns/100ps
module fio_core
  import fio_pkg::*;
#(
  parameter int unsigned NUM_INPUTS = 8
)(
  input  wire logic                  clk_sys_i,
  input  wire logic                  rst_n_i,
  input  wire logic                  par_wr_i,
  input  wire logic [9:0]            par_addr_i,
  input  wire logic [15:0]           par_wdata_i,
  output logic      [15:0]           par_rdata_o,
  input  wire fio_src_s              src_i,
  input  wire fio_scale_s            scale_i,
  input  wire logic                  transistor_out_function_i,
  input  wire logic                  freq_input_enable_i,
  input  wire logic [NUM_INPUTS-1:0] digital_input_n_i,
  input  wire logic [NUM_INPUTS-1:0] input_present_i,
  output logic                       transistor_output_pin_o
);

  typedef struct packed {
    fio_cfg_s    cfg;
    fio_state_e  fsm;
    logic [15:0] freq_hz;
    logic [15:0] pct;
    logic [31:0] acc;
    logic        fo_level;
    logic        pin;
    logic [7:0]  status;
    logic [15:0] rdata;
  } fio_core_s;

  fio_core_s   st_reg;
  fio_core_s   st_next;
  logic        div_done;
  logic [16:0] div_quot;
  logic [15:0] src_val;
  logic [16:0] src_scale;
  logic [31:0] div_num;
  logic [31:0] div_den;
  logic [7:0]  pnp_mask;
  logic [7:0]  status_now;

  always_comb
  begin
    src_val   = '0;
    src_scale = SCALE_USER;
    if (st_reg.cfg.src_sel >= SRC_APP_FIRST && st_reg.cfg.src_sel <= SRC_APP_LAST)
      src_val = src_i.app_val[3'(st_reg.cfg.src_sel - SRC_APP_FIRST)];
    else if (st_reg.cfg.src_sel >= SRC_USER_FIRST && st_reg.cfg.src_sel <= SRC_USER_LAST)
      src_val = src_i.user_val[2'(st_reg.cfg.src_sel - SRC_USER_FIRST)];
    else
    begin
      case (st_reg.cfg.src_sel)
        SRC_SPEED_REF:  begin src_val = src_i.speed_ref;
                        src_scale = {1'b0, scale_i.max_speed_setting}; end
        SRC_REAL_SPEED: begin src_val = src_i.real_speed;
                        src_scale = {1'b0, scale_i.max_speed_setting}; end
        SRC_OUT_CURR:   begin src_val = src_i.out_current;
                        src_scale = {scale_i.rated_current_setting, 1'b0}; end
        SRC_ACT_CURR:   begin src_val = src_i.act_current;
                        src_scale = {scale_i.rated_current_setting, 1'b0}; end
        SRC_PROC_VAR:   begin src_val = src_i.proc_var;
                        src_scale = {1'b0, scale_i.pid_scale_setting}; end
        SRC_PID_SP:     begin src_val = src_i.pid_setpoint;
                        src_scale = {1'b0, scale_i.pid_scale_setting}; end
        SRC_TORQUE:     begin src_val = src_i.torque;    src_scale = SCALE_TORQUE; end
        SRC_OVERLOAD:   begin src_val = src_i.overload;  src_scale = SCALE_OVLD;   end
        SRC_USER_PROG:  begin src_val = src_i.user_prog; src_scale = SCALE_USER;   end
        default:        src_val = '0;  // Unused codes drive nothing
      endcase
    end
  end

  // gain and scale ratio
  // Negative sources clamp to zero; gain is in thousandths, so scale carries it too
  assign div_num = src_val[15] ? 32'h0 : 32'({src_val[14:0]} * st_reg.cfg.gain);
  assign div_den = 32'(src_scale * GAIN_UNIT);

  fio_div u_div (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .start_i   (st_reg.fsm == FIO_ST_START),
    .num_i     (div_num),
    .den_i     (div_den),
    .done_o    (div_done),
    .quot_o    (div_quot)
  );

  always_comb
  begin
    status_now = '0;
    for (int i = 0; i < 8; i++)
    begin
      pnp_mask[i] = (4'(i) < st_reg.cfg.polarity);
      if (i < NUM_INPUTS)
        status_now[i] = input_present_i[i] &
                        (pnp_mask[i] ? digital_input_n_i[i] : ~digital_input_n_i[i]);
    end
    if (freq_input_enable_i)
      status_now[1] = 1'b0;
  end

  // Parameter writes, recompute loop, output generator and readback
  always_comb
  begin
    logic [32:0] prod;
    logic [15:0] span;
    logic [31:0] half;
    logic [31:0] sum;
    st_next = st_reg;
    prod    = '0;
    sum     = '0;
    half    = CLK_HZ;
    span    = (st_reg.cfg.max_hz > st_reg.cfg.min_hz) ?
              (st_reg.cfg.max_hz - st_reg.cfg.min_hz) : 16'h0;
    // Out-of-range writes are dropped so the setting always stays legal
    if (par_wr_i)
    begin
      unique case (par_addr_i)
        IDX_SRC_SEL:  if (par_wdata_i <= SRC_MAX) st_next.cfg.src_sel = par_wdata_i[4:0];
        IDX_GAIN:     if (par_wdata_i <= GAIN_MAX) st_next.cfg.gain = par_wdata_i[13:0];
        IDX_MIN_HZ:   if (par_wdata_i >= FREQ_MIN && par_wdata_i <= FREQ_MAX)
                        st_next.cfg.min_hz = par_wdata_i;
        IDX_MAX_HZ:   if (par_wdata_i >= FREQ_MIN && par_wdata_i <= FREQ_MAX)
                        st_next.cfg.max_hz = par_wdata_i;
        IDX_POLARITY: if (par_wdata_i <= POL_MAX) st_next.cfg.polarity = par_wdata_i[3:0];
        default:      ;
      endcase
    end
    unique case (st_reg.fsm)
      FIO_ST_START: st_next.fsm = FIO_ST_WAIT;
      FIO_ST_WAIT:
      begin
        if (div_done)
        begin
          prod            = 33'(div_quot * span);
          st_next.freq_hz = st_reg.cfg.min_hz + prod[31:16];
          prod            = 33'(div_quot * PCT_UNIT);
          st_next.pct     = prod[31:16];
          st_next.fsm     = FIO_ST_START;
        end
      end
    endcase
    // Half-period accumulator; frequency is fixed-point exact, so no drift
    sum  = st_reg.acc + {15'h0, st_reg.freq_hz, 1'b0};
    if (sum >= half)
    begin
      st_next.acc      = sum - half;
      st_next.fo_level = ~st_reg.fo_level;
    end
    else
      st_next.acc = sum;
    if (st_reg.cfg.src_sel == SRC_DISABLED)
      st_next.pin = transistor_out_function_i;
    else
      st_next.pin = st_reg.fo_level;
    st_next.status = status_now;
    case (par_addr_i)
      IDX_STATUS:   st_next.rdata = {8'h0, st_reg.status};
      IDX_FO_PCT:   st_next.rdata = st_reg.pct;
      IDX_FO_HZ:    st_next.rdata = st_reg.freq_hz;
      IDX_SRC_SEL:  st_next.rdata = {11'h0, st_reg.cfg.src_sel};
      IDX_GAIN:     st_next.rdata = {2'h0, st_reg.cfg.gain};
      IDX_MIN_HZ:   st_next.rdata = st_reg.cfg.min_hz;
      IDX_MAX_HZ:   st_next.rdata = st_reg.cfg.max_hz;
      IDX_POLARITY: st_next.rdata = {12'h0, st_reg.cfg.polarity};
      default:      st_next.rdata = '0;
    endcase
  end

  // State register; reset restores factory settings
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      st_reg              <= '0;
      st_reg.fsm          <= FIO_ST_START;
      st_reg.cfg.src_sel  <= RST_SRC_SEL[4:0];
      st_reg.cfg.gain     <= RST_GAIN[13:0];
      st_reg.cfg.min_hz   <= RST_MIN_HZ;
      st_reg.cfg.max_hz   <= RST_MAX_HZ;
      st_reg.cfg.polarity <= RST_POLARITY[3:0];
      st_reg.freq_hz      <= RST_MIN_HZ;
    end
    else
      st_reg <= st_next;
  end

  assign par_rdata_o             = st_reg.rdata;
  assign transistor_output_pin_o = st_reg.pin;

  property p_pin_digital;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (st_reg.cfg.src_sel == SRC_DISABLED) |=> (st_reg.pin == $past(transistor_out_function_i));
  endproperty
  a_pin_digital: assert property (p_pin_digital) else $error("pin not digital");

  property p_pin_fo;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (st_reg.cfg.src_sel != SRC_DISABLED) |=> (st_reg.pin == $past(st_reg.fo_level));
  endproperty
  a_pin_fo: assert property (p_pin_fo) else $error("pin not frequency output");

  property p_gain_range;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (par_wr_i && par_addr_i == IDX_GAIN && par_wdata_i > GAIN_MAX)
        |=> $stable(st_reg.cfg.gain);
  endproperty
  a_gain_range: assert property (p_gain_range) else $error("gain took bad value");

  property p_min_take;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (par_wr_i && par_addr_i == IDX_MIN_HZ && par_wdata_i >= FREQ_MIN
       && par_wdata_i <= FREQ_MAX) |=> (st_reg.cfg.min_hz == $past(par_wdata_i));
  endproperty
  a_min_take: assert property (p_min_take) else $error("minimum not taken");

  property p_max_range;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (par_wr_i && par_addr_i == IDX_MAX_HZ && par_wdata_i > FREQ_MAX)
        |=> $stable(st_reg.cfg.max_hz);
  endproperty
  a_max_range: assert property (p_max_range) else $error("maximum took bad value");

  property p_pct_cap;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      st_reg.pct <= 16'(PCT_UNIT);
  endproperty
  a_pct_cap: assert property (p_pct_cap) else $error("percent above full");

  property p_freq_band;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (st_reg.fsm == FIO_ST_WAIT && div_done)
        |=> (st_reg.freq_hz >= $past(st_reg.cfg.min_hz));
  endproperty
  a_freq_band: assert property (p_freq_band) else $error("frequency below minimum");

  property p_absent;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      ##1 ((st_reg.status[NUM_INPUTS-1:0] & ~$past(input_present_i)) == '0);
  endproperty
  a_absent: assert property (p_absent) else $error("absent input active");

  property p_npn_all;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (st_reg.cfg.polarity == 4'h0 && !freq_input_enable_i && (&input_present_i))
        |=> (st_reg.status[NUM_INPUTS-1:0] == ~$past(digital_input_n_i));
  endproperty
  a_npn_all: assert property (p_npn_all) else $error("NPN status wrong");

  property p_fin_hold;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      freq_input_enable_i |=> (st_reg.status[1] == 1'b0);
  endproperty
  a_fin_hold: assert property (p_fin_hold) else $error("input two not held");

endmodule : fio_core

// [shared/fio_pkg.sv]
package fio_pkg;

  // Clock rate, used to turn output frequencies into half-period counts
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned CLK_HZ        = 1000000000 / CLK_PERIOD_NS;

  // Parameter indices on the parameter port
  localparam logic [9:0] IDX_STATUS   = 10'h00c;
  localparam logic [9:0] IDX_FO_PCT   = 10'h010;
  localparam logic [9:0] IDX_FO_HZ    = 10'h011;
  localparam logic [9:0] IDX_SRC_SEL  = 10'h101;
  localparam logic [9:0] IDX_GAIN     = 10'h102;
  localparam logic [9:0] IDX_MIN_HZ   = 10'h103;
  localparam logic [9:0] IDX_MAX_HZ   = 10'h104;
  localparam logic [9:0] IDX_POLARITY = 10'h10f;

  // Factory values
  localparam logic [15:0] RST_SRC_SEL  = 16'h000f;
  localparam logic [15:0] RST_GAIN     = 16'h03e8;
  localparam logic [15:0] RST_MIN_HZ   = 16'h000a;
  localparam logic [15:0] RST_MAX_HZ   = 16'h2710;
  localparam logic [15:0] RST_POLARITY = 16'h0000;

  // Accepted ranges
  localparam logic [15:0] GAIN_MAX     = 16'h270f;
  localparam logic [15:0] FREQ_MIN     = 16'h000a;
  localparam logic [15:0] FREQ_MAX     = 16'h4e20;
  localparam logic [15:0] POL_MAX      = 16'h0008;
  localparam logic [15:0] SRC_MAX      = 16'h001c;

  // Fixed full scales; torque and overload in 0.1 % units
  localparam logic [16:0] SCALE_TORQUE = 17'h007d0;
  localparam logic [16:0] SCALE_OVLD   = 17'h003e8;
  localparam logic [16:0] SCALE_USER   = 17'h07fff;
  localparam logic [9:0]  GAIN_UNIT    = 10'h3e8;
  localparam logic [9:0]  PCT_UNIT     = 10'h3e8;
  localparam logic [16:0] RATIO_ONE    = 17'h10000;

  // Source select codes
  localparam logic [4:0] SRC_SPEED_REF  = 5'h00;
  localparam logic [4:0] SRC_REAL_SPEED = 5'h02;
  localparam logic [4:0] SRC_OUT_CURR   = 5'h05;
  localparam logic [4:0] SRC_PROC_VAR   = 5'h06;
  localparam logic [4:0] SRC_ACT_CURR   = 5'h07;
  localparam logic [4:0] SRC_PID_SP     = 5'h09;
  localparam logic [4:0] SRC_TORQUE     = 5'h0b;
  localparam logic [4:0] SRC_USER_PROG  = 5'h0c;
  localparam logic [4:0] SRC_DISABLED   = 5'h0f;
  localparam logic [4:0] SRC_OVERLOAD   = 5'h10;
  localparam logic [4:0] SRC_USER_FIRST = 5'h12;
  localparam logic [4:0] SRC_USER_LAST  = 5'h14;
  localparam logic [4:0] SRC_APP_FIRST  = 5'h15;
  localparam logic [4:0] SRC_APP_LAST   = 5'h1c;

  // Monitored quantities, signed
  typedef struct packed {
    logic signed [15:0]       speed_ref;
    logic signed [15:0]       real_speed;
    logic signed [15:0]       out_current;
    logic signed [15:0]       proc_var;
    logic signed [15:0]       act_current;
    logic signed [15:0]       pid_setpoint;
    logic signed [15:0]       torque;
    logic signed [15:0]       user_prog;
    logic signed [15:0]       overload;
    logic [2:0][15:0]         user_val;
    logic [7:0][15:0]         app_val;
  } fio_src_s;

  // Scale settings owned by other parts of the drive
  typedef struct packed {
    logic [15:0] max_speed_setting;
    logic [15:0] rated_current_setting;
    logic [15:0] pid_scale_setting;
  } fio_scale_s;

  typedef struct packed {
    logic [4:0]  src_sel;
    logic [13:0] gain;
    logic [15:0] min_hz;
    logic [15:0] max_hz;
    logic [3:0]  polarity;
  } fio_cfg_s;

  typedef enum logic [1:0] {
    FIO_ST_START = 2'b01,
    FIO_ST_WAIT  = 2'b10
  } fio_state_e;

endpackage : fio_pkg

// [hw/fio_div.sv]
`timescale 1ns/100ps
// Fraction num/den as a 16-bit binary fraction, saturated at 1.0
module fio_div
  import fio_pkg::*;
(
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  input  wire logic        start_i,
  input  wire logic [31:0] num_i,
  input  wire logic [31:0] den_i,
  output logic             done_o,
  output logic [16:0]      quot_o
);

  typedef struct packed {
    logic        busy;
    logic [4:0]  cnt;
    logic [32:0] rem;
    logic [31:0] den;
    logic [15:0] q;
    logic        done;
    logic [16:0] quot;
  } fio_div_s;

  fio_div_s st_reg;
  fio_div_s st_next;

  // One quotient bit per cycle; a ratio at or above one skips the loop
  always_comb
  begin
    logic [32:0] r2;
    logic        qb;
    r2      = '0;
    qb      = 1'b0;
    st_next = st_reg;
    st_next.done = 1'b0;
    if (!st_reg.busy && start_i)
    begin
      if (num_i == 32'h0)
      begin
        st_next.quot = '0;
        st_next.done = 1'b1;
      end
      else if (num_i >= den_i)
      begin
        st_next.quot = RATIO_ONE;
        st_next.done = 1'b1;
      end
      else
      begin
        st_next.busy = 1'b1;
        st_next.cnt  = 5'h10;
        st_next.rem  = {1'b0, num_i};
        st_next.den  = den_i;
      end
    end
    else if (st_reg.busy)
    begin
      r2 = {st_reg.rem[31:0], 1'b0};
      if (r2 >= {1'b0, st_reg.den})
      begin
        r2 = r2 - {1'b0, st_reg.den};
        qb = 1'b1;
      end
      st_next.rem = r2;
      st_next.q   = {st_reg.q[14:0], qb};
      st_next.cnt = st_reg.cnt - 5'h01;
      if (st_reg.cnt == 5'h01)
      begin
        st_next.busy = 1'b0;
        st_next.done = 1'b1;
        st_next.quot = {1'b0, st_reg.q[14:0], qb};
      end
    end
  end

  // State register
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign done_o = st_reg.done;
  assign quot_o = st_reg.quot;

  property p_div_bounded;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (start_i && !st_reg.busy) |-> ##[1:17] st_reg.done;
  endproperty
  a_div_bounded: assert property (p_div_bounded) else $error("divider did not finish");

endmodule : fio_div

// [dv/fio_field_model.sv]
`timescale 1ns/100ps
// Field side of the drive: input contacts and a counter on the transistor pin
module fio_field_model
(
  input  wire logic       clk_sys_i,
  input  wire logic [7:0] level_i,
  input  wire logic [7:0] present_i,
  input  wire logic       pin_i,
  input  wire logic       clr_i,
  output logic      [7:0] din_o,
  output int              edges_o
);
  logic [7:0] wiggle_reg = 8'h55;
  logic       pin_reg    = 1'b0;

  // Absent contacts float, so they show a level that changes every cycle
  always_ff @(posedge clk_sys_i)
  begin
    wiggle_reg <= ~wiggle_reg;
  end
  assign din_o = (level_i & present_i) | (wiggle_reg & ~present_i);

  // Every pin change is counted; two changes make one output period
  always_ff @(posedge clk_sys_i)
  begin
    pin_reg <= pin_i;
    if (clr_i)
      edges_o <= 0;
    else if (pin_i !== pin_reg)
      edges_o <= edges_o + 1;
  end
endmodule : fio_field_model

// [dv/freq_out_and_input_status_test.sv]
`timescale 1ns/100ps
`define CHK(got, exp, msg) \
  begin \
    n_checks++; \
    if ((got) !== (exp)) \
    begin \
      fail_count++; \
      $display("wrong value at %0t: %s got %h want %h", $time, msg, got, exp); \
    end \
  end

module freq_out_and_input_status_test
  import fio_pkg::*;
;
  logic             clk_sys_i = 1'b0;
  logic             rst_n_i;
  logic             par_wr_i;
  logic [9:0]       par_addr_i;
  logic [15:0]      par_wdata_i;
  logic [15:0]      par_rdata_o;
  fio_src_s         src_i;
  fio_scale_s       scale_i;
  logic             out_func;
  logic             fin_en;
  logic [7:0]       level;
  logic [7:0]       present;
  logic [7:0]       din;
  logic             pin;
  logic             clr;
  int               edges;
  int               seed = 9;
  int               fail_count = 0;
  int               n_checks = 0;
  int               cycles = 0;
  logic [15:0]      rd_q;
  bit               ok;
  logic [7:0]       lv;
  logic [7:0]       pr;
  logic             fi;
  int               pol;
  logic             b;
  // Write, then readback: stored value, the old one when refused, zero for the unknown index
  logic [9:0]       t_a [15] = '{IDX_GAIN, IDX_GAIN, IDX_MIN_HZ, IDX_MIN_HZ, IDX_MIN_HZ,
    IDX_MIN_HZ, IDX_MAX_HZ, IDX_MAX_HZ, IDX_MAX_HZ, IDX_MAX_HZ, IDX_POLARITY, IDX_POLARITY,
    IDX_SRC_SEL, IDX_SRC_SEL, 10'h3ff};
  logic [15:0]      t_d [15] = '{16'h270f, 16'h2710, 16'h0009, 16'h4e20, 16'h4e21, 16'h000a,
    16'h0009, 16'h4e20, 16'h4e21, 16'h2710, 16'h0008, 16'h0009, 16'h001c, 16'h001d, 16'h1234};
  logic [15:0]      t_e [15] = '{16'h270f, 16'h270f, 16'h000a, 16'h4e20, 16'h4e20, 16'h000a,
    16'h2710, 16'h4e20, 16'h4e20, 16'h2710, 16'h0008, 16'h0008, 16'h001c, 16'h001c, 16'h0000};

  fio_core #(
    .NUM_INPUTS (8)
  ) u_fio_core (
    .clk_sys_i                 (clk_sys_i),
    .rst_n_i                   (rst_n_i),
    .par_wr_i                  (par_wr_i),
    .par_addr_i                (par_addr_i),
    .par_wdata_i               (par_wdata_i),
    .par_rdata_o               (par_rdata_o),
    .src_i                     (src_i),
    .scale_i                   (scale_i),
    .transistor_out_function_i (out_func),
    .freq_input_enable_i       (fin_en),
    .digital_input_n_i         (din),
    .input_present_i           (present),
    .transistor_output_pin_o   (pin)
  );

  fio_field_model u_fio_field_model (
    .clk_sys_i (clk_sys_i),
    .level_i   (level),
    .present_i (present),
    .pin_i     (pin),
    .clr_i     (clr),
    .din_o     (din),
    .edges_o   (edges)
  );

  // 200 MHz clock
  initial
  begin
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end

  // Hang guard, well above the roughly 22500 cycles the run needs
  always @(posedge clk_sys_i)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      fail_count++;
      stop_test();
    end
  end

  task automatic stop_test;
    if (fail_count == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : stop_test

  task automatic wr(input logic [9:0] a, input logic [15:0] d);
    @(posedge clk_sys_i);
    par_wr_i    <= 1'b1;
    par_addr_i  <= a;
    par_wdata_i <= d;
    @(posedge clk_sys_i);
    par_wr_i <= 1'b0;
  endtask : wr

  // One spare edge beyond the registered readback keeps status reads settled
  task automatic rd(input logic [9:0] a);
    @(posedge clk_sys_i);
    par_addr_i <= a;
    repeat (3) @(posedge clk_sys_i);
    #1 rd_q = par_rdata_o;
  endtask : rd

  // Selected quantity at its full scale; unused codes see every source busy
  task automatic set_src(input int c, output bit valid);
    fio_src_s s;
    s = '0;
    valid = 1'b1;
    case (c) inside
      0:       s.speed_ref    = 16'h03e8;
      2:       s.real_speed   = 16'h03e8;
      5:       s.out_current  = 16'h03e8;
      6:       s.proc_var     = 16'h03e8;
      7:       s.act_current  = 16'h03e8;
      9:       s.pid_setpoint = 16'h03e8;
      11:      s.torque       = 16'h07d0;
      12:      s.user_prog    = 16'h7fff;
      16:      s.overload     = 16'h03e8;
      [18:20]: s.user_val[c-18] = 16'h7fff;
      [21:28]: s.app_val[c-21]  = 16'h7fff;
      default:
      begin
        s = {20{16'h03e8}};
        valid = 1'b0;
      end
    endcase
    @(posedge clk_sys_i);
    src_i <= s;
  endtask : set_src

  function automatic logic [15:0] exp_hz(int r, int hi);
    return 16'(10 + (r * (hi - 10)) / 65536);
  endfunction : exp_hz

  function automatic logic [7:0] exp_status(logic [7:0] l, logic [7:0] p, int n, logic f);
    logic [7:0] s;
    for (int i = 0; i < 8; i++)
      s[i] = p[i] & ((i < n) ? l[i] : ~l[i]);
    if (f)
      s[1] = 1'b0;
    return s;
  endfunction : exp_status

  initial
  begin
    rst_n_i     = 1'b0;
    par_wr_i    = 1'b0;
    par_addr_i  = '0;
    par_wdata_i = '0;
    src_i       = '0;
    scale_i     = '{16'h03e8, 16'h01f4, 16'h03e8};
    out_func    = 1'b0;
    fin_en      = 1'b0;
    level       = '0;
    present     = 8'hff;
    clr         = 1'b0;
    repeat (12) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    // Factory values
    rd(IDX_SRC_SEL);
    `CHK(rd_q, RST_SRC_SEL, "source reset")
    rd(IDX_GAIN);
    `CHK(rd_q, 16'h03e8, "gain reset")
    rd(IDX_MIN_HZ);
    `CHK(rd_q, 16'h000a, "min reset")
    rd(IDX_MAX_HZ);
    `CHK(rd_q, 16'h2710, "max reset")
    // Output disabled: pin is the plain digital output
    repeat (6)
    begin
      b = 1'($random(seed));
      @(posedge clk_sys_i);
      out_func <= b;
      repeat (2) @(posedge clk_sys_i);
      #1 `CHK(pin, b, "digital pin")
    end
    // Range boundaries, refused writes, unknown index
    for (int k = 0; k < 15; k++)
    begin
      wr(t_a[k], t_d[k]);
      rd(t_a[k]);
      `CHK(rd_q, t_e[k], "range")
    end
    // Random contacts, presence, polarity and frequency input enable
    repeat (24)
    begin
      lv  = 8'($random(seed));
      pr  = 8'($random(seed));
      fi  = 1'($random(seed));
      pol = $unsigned($random(seed)) % 9;
      wr(IDX_POLARITY, 16'(pol));
      @(posedge clk_sys_i);
      level   <= lv;
      present <= pr;
      fin_en  <= fi;
      wr(IDX_STATUS, 16'h00ff);
      rd(IDX_STATUS);
      `CHK(rd_q, {8'h00, exp_status(lv, pr, pol, fi)}, "status")
    end
    // Every source code except SRC_DISABLED at full scale with gain one half
    wr(IDX_GAIN, 16'h01f4);
    for (int c = 0; c < 29; c++)
    begin
      if (c != 15)
      begin
        wr(IDX_SRC_SEL, 16'(c));
        set_src(c, ok);
        repeat (60) @(posedge clk_sys_i);
        rd(IDX_FO_HZ);
        `CHK(rd_q, ok ? exp_hz(32768, 10000) : 16'h000a, "hz")
        rd(IDX_FO_PCT);
        `CHK(rd_q, ok ? 16'h01f4 : 16'h0000, "percent")
      end
    end
    // Gain two clamps to the top of the band
    wr(IDX_GAIN, 16'h07d0);
    wr(IDX_SRC_SEL, 16'h0000);
    set_src(0, ok);
    repeat (60) @(posedge clk_sys_i);
    rd(IDX_FO_HZ);
    `CHK(rd_q, 16'h2710, "clamp high")
    rd(IDX_FO_PCT);
    `CHK(rd_q, 16'h03e8, "percent top")
    // Negative quantity clamps to the bottom
    @(posedge clk_sys_i);
    src_i.speed_ref <= 16'hfc18;
    repeat (60) @(posedge clk_sys_i);
    rd(IDX_FO_HZ);
    `CHK(rd_q, 16'h000a, "clamp low")
    // 20 kHz on the pin: 5000-cycle half period, about four changes in 20000
    wr(IDX_GAIN, 16'h03e8);
    wr(IDX_MAX_HZ, 16'h4e20);
    set_src(0, ok);
    repeat (60) @(posedge clk_sys_i);
    clr <= 1'b1;
    @(posedge clk_sys_i);
    clr <= 1'b0;
    repeat (20000) @(posedge clk_sys_i);
    `CHK(edges >= 3 && edges <= 5, 1'b1, "pin rate")
    stop_test();
  end
endmodule : freq_out_and_input_status_test
